// ---- hw/luc_pkg.sv ----
// constants, register map and carrier types of the loadable 16-bit up counter
// assumes one 100 MHz clock domain shared by the counter and its wishbone bus
package luc_pkg;
  localparam int unsigned LUC_WIDTH = 16;
  localparam int unsigned LUC_LOW_GROUP = 4;
  localparam int unsigned LUC_DIRECT_BITS = 6;
  localparam int unsigned LUC_DUP_FROM = 11;
  localparam int unsigned LUC_ADR_W = 8;
  localparam logic [7:0] LUC_ADR_CTRL = 8'h00;
  localparam logic [7:0] LUC_ADR_DATA = 8'h04;
  localparam logic [7:0] LUC_ADR_COUNT = 8'h08;
  localparam int unsigned LUC_CTRL_EN_BIT = 0;
  localparam int unsigned LUC_CTRL_LOAD_BIT = 1;
  localparam logic LUC_CTRL_EN_RST = 1'b0;
  localparam logic [15:0] LUC_DATA_RST = 16'h0000;
  localparam logic [15:0] LUC_COUNT_RST = 16'h0000;
  localparam logic [31:0] LUC_READ_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic load;
    logic count_en;
    logic [LUC_WIDTH-1:0] data;
  } luc_ctrl_t;

  typedef struct packed {
    logic load_select;
    logic count_select;
  } luc_sel_t;
endpackage : luc_pkg

// ---- hw/luc_bit_cell.sv ----
// one counter bit: four-way selector in front of a storage flip-flop
// assumes clear is already merged into one asynchronous active-high input
`timescale 1ns/1ps
module luc_bit_cell
  import luc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic clr_i,
  input wire luc_pkg::luc_sel_t sel_i,
  input wire logic load_bit_i,
  input wire logic inc_bit_i,
  output logic q_o
);
  import luc_pkg::*;

  logic bit_d;
  logic bit_q;

  // select codes: 00 hold, 01 incremented value, 1x load data
  always_comb
  begin
    bit_d = bit_q;
    unique case ({sel_i.load_select, sel_i.count_select})
      2'b00: bit_d = bit_q;
      2'b01: bit_d = inc_bit_i;
      2'b10: bit_d = load_bit_i;
      2'b11: bit_d = load_bit_i;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge clr_i)
  begin
    if (clr_i)
      bit_q <= 1'b0;
    else
      bit_q <= bit_d;
  end

  assign q_o = bit_q;
endmodule : luc_bit_cell

// ---- hw/luc_counter16.sv ----
// loadable synchronous up counter with wishbone control and status
// assumes load, data and enable come from logic on ref_clk_i; clear_n may be asynchronous
`timescale 1ns/1ps
module luc_counter16
  import luc_pkg::*;
#(
  parameter int unsigned WIDTH = LUC_WIDTH
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clear_n_i,
  input wire logic load_strobe_i,
  input wire logic [WIDTH-1:0] load_data_i,
  input wire logic count_enable_n_i,
  output logic [WIDTH-1:0] count_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [LUC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import luc_pkg::*;

  logic clr;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] count_n;
  logic count1_n_dup;
  logic [WIDTH-1:0] carry;
  logic en;
  logic group_lo;
  logic group_lo_dup;
  luc_ctrl_t eff;

  logic ack_d;
  logic ack_q;
  logic [31:0] dat_d;
  logic [31:0] dat_q;
  logic ctrl_en_d;
  logic ctrl_en_q;
  logic load_pulse_d;
  logic load_pulse_q;
  logic [WIDTH-1:0] data_d;
  logic [WIDTH-1:0] data_q;
  logic req;
  logic hit_ctrl;
  logic hit_data;
  logic hit_count;

  // clear wins over everything, including the clock
  assign clr = rst_i | ~clear_n_i;

  // user strobe takes the data lanes when both sources load together
  always_comb
  begin
    eff.load = load_strobe_i | load_pulse_q;
    eff.count_en = ~count_enable_n_i | ctrl_en_q;
    eff.data = load_strobe_i ? load_data_i : data_q;
  end

  assign en = eff.count_en;
  assign count_n = ~count;
  // second inverter for bit one splits the load of the low bits
  assign count1_n_dup = ~count[1];

  // first level: grouped terms of the four lowest bits, gated by enable
  assign group_lo = en & (&count[LUC_LOW_GROUP-1:0]);
  // same term again so the top bits do not load the first copy
  assign group_lo_dup = en & (&count[LUC_LOW_GROUP-1:0]);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      luc_sel_t sel;
      logic inc_bit;
      if (gi == 0)
      begin : g_lsb
        assign carry[gi] = en;
      end
      else if (gi < LUC_DIRECT_BITS)
      begin : g_low
        assign carry[gi] = en & (&count[gi-1:0]);
      end
      else if (gi < LUC_DUP_FROM)
      begin : g_mid
        assign carry[gi] = group_lo & (&count[gi-1:LUC_LOW_GROUP]);
      end
      else
      begin : g_top
        assign carry[gi] = group_lo_dup & (&count[gi-1:LUC_LOW_GROUP]);
      end
      if (gi == 1)
      begin : g_inc_dup
        assign inc_bit = count1_n_dup;
      end
      else
      begin : g_inc
        assign inc_bit = count_n[gi];
      end
      assign sel.load_select = eff.load;
      assign sel.count_select = carry[gi];
      luc_bit_cell u_cell (
        .ref_clk_i(ref_clk_i),
        .clr_i(clr),
        .sel_i(sel),
        .load_bit_i(eff.data[gi]),
        .inc_bit_i(inc_bit),
        .q_o(count[gi])
      );
    end
  endgenerate

  assign count_o = count;

  // wishbone slave: one wait-free answer, ack one cycle after the request
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign hit_ctrl = (wb_adr_i == LUC_ADR_CTRL);
  assign hit_data = (wb_adr_i == LUC_ADR_DATA);
  assign hit_count = (wb_adr_i == LUC_ADR_COUNT);

  always_comb
  begin
    ack_d = req;
    dat_d = dat_q;
    ctrl_en_d = ctrl_en_q;
    load_pulse_d = 1'b0;
    data_d = data_q;
    if (req && wb_we_i)
    begin
      if (hit_ctrl && wb_sel_i[0])
      begin
        ctrl_en_d = wb_dat_i[LUC_CTRL_EN_BIT];
        load_pulse_d = wb_dat_i[LUC_CTRL_LOAD_BIT];
      end
      if (hit_data && wb_sel_i[0])
        data_d[7:0] = wb_dat_i[7:0];
      if (hit_data && wb_sel_i[1])
        data_d[WIDTH-1:8] = wb_dat_i[WIDTH-1:8];
    end
    if (req && !wb_we_i)
    begin
      dat_d = LUC_READ_ZERO;
      if (hit_ctrl)
        dat_d[LUC_CTRL_EN_BIT] = ctrl_en_q;
      if (hit_data)
        dat_d[WIDTH-1:0] = data_q;
      if (hit_count)
        dat_d[WIDTH-1:0] = count;
    end
  end

  // bus state is not cleared by clear_n: software setup survives a count clear
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= LUC_READ_ZERO;
      ctrl_en_q <= LUC_CTRL_EN_RST;
      load_pulse_q <= 1'b0;
      data_q <= LUC_DATA_RST;
    end
    else
    begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      ctrl_en_q <= ctrl_en_d;
      load_pulse_q <= load_pulse_d;
      data_q <= data_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // checks
  sequence seq_load_req;
    eff.load;
  endsequence

  sequence seq_count_req;
    !eff.load && eff.count_en;
  endsequence

  sequence seq_hold_req;
    !eff.load && !eff.count_en;
  endsequence

  property p_clear_zero;
    @(posedge ref_clk_i) disable iff (rst_i)
      !clear_n_i |-> (count_o == LUC_COUNT_RST);
  endproperty

  chk_clear_zero: assert property (p_clear_zero)
    else $error("count not zero while clear is low");

  chk_load_stores: assert property (
    @(posedge ref_clk_i) disable iff (clr)
      seq_load_req |=> (count_o == $past(eff.data)))
    else $error("load did not store the data");

  chk_load_priority: assert property (
    @(posedge ref_clk_i) disable iff (clr)
      (eff.load && eff.count_en) |=> (count_o == $past(eff.data)))
    else $error("count overrode load");

  chk_count_hold: assert property (
    @(posedge ref_clk_i) disable iff (clr)
      seq_hold_req |=> $stable(count_o))
    else $error("count moved while disabled");

  chk_count_step: assert property (
    @(posedge ref_clk_i) disable iff (clr)
      seq_count_req |=> (count_o == WIDTH'($past(count_o) + 1'b1)))
    else $error("count did not add one");

  // bit zero must flip on every single enabled count, not merely every second one
  chk_lsb_toggle: assert property (
    @(posedge ref_clk_i) disable iff (clr)
      seq_count_req |=> (count_o[0] != $past(count_o[0])))
    else $error("bit zero did not toggle on each count");

  chk_upper_carry: assert property (
    @(posedge ref_clk_i) disable iff (clr)
      carry[WIDTH-1] == (en && (&count[WIDTH-2:0])))
    else $error("top carry disagrees with lower bits");

  chk_msb_invert: assert property (
    @(posedge ref_clk_i) disable iff (clr)
      (seq_count_req and (count_o[WIDTH-2:0] != {(WIDTH-1){1'b1}}))
        |=> (count_o[WIDTH-1] == $past(count_o[WIDTH-1])))
    else $error("top bit moved without a full carry");

  // copies are held against the output bits, so a miswired copy shows up here
  chk_dup_match: assert property (
    @(posedge ref_clk_i) disable iff (clr)
      (group_lo_dup == (eff.count_en && (&count_o[LUC_LOW_GROUP-1:0])))
        && (count1_n_dup != count_o[1]))
    else $error("duplicate copies disagree");

  chk_ack_single: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  chk_ack_timing: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");

  chk_sw_load: assert property (
    @(posedge ref_clk_i) disable iff (clr)
      (req && wb_we_i && hit_ctrl && wb_sel_i[0] && wb_dat_i[LUC_CTRL_LOAD_BIT]
        && !load_strobe_i) ##1 !load_strobe_i |=> (count_o == $past(data_q)))
    else $error("software load did not reach the count");

  chk_read_count: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      (req && !wb_we_i && hit_count) |=> (wb_dat_o[WIDTH-1:0] == $past(count)))
    else $error("count read returned the wrong value");
endmodule : luc_counter16

// ---- bench/luc_user_model.sv ----
// model of the user logic that drives load, data, enable and clear of the counter
// assumes one shared 100 MHz clock; all changes land just after a rising edge
`timescale 1ns/1ps
module luc_user_model
  import luc_pkg::*;
(
  input wire logic ref_clk_i,
  output logic clear_n_o,
  output logic load_strobe_o,
  output logic [luc_pkg::LUC_WIDTH-1:0] load_data_o,
  output logic count_enable_n_o
);
  initial
  begin
    clear_n_o = 1'b1;
    load_strobe_o = 1'b0;
    load_data_o = 16'hA5A5;
    count_enable_n_o = 1'b1;
  end

  task automatic load_word(input logic [LUC_WIDTH-1:0] value, input logic with_count);
    @(posedge ref_clk_i);
    load_strobe_o <= 1'b1;
    load_data_o <= value;
    count_enable_n_o <= ~with_count;
    @(posedge ref_clk_i);
    load_strobe_o <= 1'b0;
    // data is stale once the strobe drops, so show something else
    load_data_o <= ~value;
    count_enable_n_o <= 1'b1;
  endtask : load_word

  task automatic count_up(input int n);
    @(posedge ref_clk_i);
    count_enable_n_o <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
    count_enable_n_o <= 1'b1;
  endtask : count_up

  task automatic set_clear(input logic active);
    @(posedge ref_clk_i);
    clear_n_o <= ~active;
    // a pending load during clear must lose
    load_strobe_o <= active;
    load_data_o <= 16'h5555;
  endtask : set_clear
endmodule : luc_user_model

// ---- bench/luc_counter16_tb.sv ----
// self-checking bench for the loadable up counter and its wishbone registers
// assumes the partner model drives the counter controls on the same clock
`timescale 1ns/1ps
module luc_counter16_tb;
  import luc_pkg::*;
  localparam logic [15:0] ROLL [4] = '{16'hFFFF, 16'h00FF, 16'h0FFF, 16'h7FFF};
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic clear_n, load_strobe, count_enable_n;
  logic [15:0] load_data, count_o;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  int mismatches = 0;
  int comparisons = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  luc_user_model luc_user_model_i (.ref_clk_i(ref_clk_i), .clear_n_o(clear_n),
    .load_strobe_o(load_strobe), .load_data_o(load_data), .count_enable_n_o(count_enable_n));

  luc_counter16 luc_counter16_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clear_n_i(clear_n),
    .load_strobe_i(load_strobe), .load_data_i(load_data), .count_enable_n_i(count_enable_n),
    .count_o(count_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

  // count compare stays 16 bits wide so a wrap to zero is not padded into a carry
  task automatic check_count(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t count %h expected %h", $time, got, exp);
    end
  endtask : check_count

  task automatic check_read(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t read %h expected %h", $time, got, exp);
    end
  endtask : check_read

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                    output logic [31:0] rdat);
    int n;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= wdat;
    for (n = 0; n < 50; n++)
    begin
      @(posedge ref_clk_i);
      if (wb_ack_o === 1'b1)
        break;
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n == 50)
    begin
      mismatches++;
      $display("[FAIL] t=%0t no bus acknowledge", $time);
      tally_and_finish();
    end
  endtask : wb

  initial
  begin
    logic [31:0] r;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1;
    check_count(count_o, LUC_COUNT_RST);
    wb(1'b0, LUC_ADR_CTRL, 32'h0000_0000, r);
    check_read(r, LUC_READ_ZERO);
    wb(1'b0, LUC_ADR_DATA, 32'h0000_0000, r);
    check_read(r, {16'h0000, LUC_DATA_RST});
    $display("test reset done");
    luc_user_model_i.load_word(16'h1234, 1'b0);
    #1;
    check_count(count_o, 16'h1234);
    luc_user_model_i.count_up(3);
    #1;
    check_count(count_o, 16'h1237);
    repeat (2) @(posedge ref_clk_i);
    #1;
    check_count(count_o, 16'h1237);
    luc_user_model_i.load_word(16'hABCD, 1'b1);
    #1;
    check_count(count_o, 16'hABCD);
    $display("test load and count done");
    foreach (ROLL[i])
    begin
      luc_user_model_i.load_word(ROLL[i], 1'b0);
      luc_user_model_i.count_up(1);
      #1;
      check_count(count_o, ROLL[i] + 16'h0001);
    end
    $display("test carries done");
    wb(1'b1, LUC_ADR_DATA, 32'h0000_BEEF, r);
    wb(1'b1, LUC_ADR_CTRL, 32'h0000_0002, r);
    @(posedge ref_clk_i);
    #1;
    check_count(count_o, 16'hBEEF);
    wb(1'b0, LUC_ADR_CTRL, 32'h0000_0000, r);
    check_read(r, LUC_READ_ZERO);
    wb(1'b1, LUC_ADR_CTRL, 32'h0000_0001, r);
    wb(1'b1, LUC_ADR_CTRL, 32'h0000_0000, r);
    #1;
    check_count(count_o, 16'hBEF2);
    wb(1'b0, LUC_ADR_COUNT, 32'h0000_0000, r);
    check_read(r, 32'h0000_BEF2);
    wb(1'b1, 8'h0C, 32'h1234_5678, r);
    wb(1'b0, 8'h0C, 32'h0000_0000, r);
    check_read(r, LUC_READ_ZERO);
    $display("test bus done");
    luc_user_model_i.set_clear(1'b1);
    #1;
    check_count(count_o, 16'h0000);
    repeat (3) @(posedge ref_clk_i);
    #1;
    check_count(count_o, 16'h0000);
    luc_user_model_i.set_clear(1'b0);
    @(posedge ref_clk_i);
    #1;
    check_count(count_o, 16'h0000);
    wb(1'b0, LUC_ADR_DATA, 32'h0000_0000, r);
    check_read(r, 32'h0000_BEEF);
    $display("test clear done");
    tally_and_finish();
  end
endmodule : luc_counter16_tb
